// file: hw/alb_ctrl.sv
// Loopback routing and S/PDIF transmit mode control with register port
`timescale 1ns/100ps

module alb_ctrl
  import alb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [alb_pkg::AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [alb_pkg::NSER-1:0] ser_dir_in,
  input wire logic [alb_pkg::NSER-1:0] ser_tx_bit_in,
  input wire logic [alb_pkg::NSER-1:0] pin_data_in,
  output logic [alb_pkg::NSER-1:0] pin_data_out,
  output logic [alb_pkg::NSER-1:0] pin_oe_b_out,
  output logic [alb_pkg::NSER-1:0] ser_rx_bit_out,
  input wire logic tx_slot_odd_in,
  output logic rx_use_tx_gen_out,
  output logic spdif_transmit_mode_out,
  output logic tx_sm_rst_b_out,
  output logic tx_ser_clr_b_out,
  output logic tx_clkdiv_rst_b_out,
  output logic tx_hfdiv_rst_b_out,
  input wire logic [alb_pkg::DW-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  output logic [alb_pkg::DW-1:0] enc_sample_out,
  output logic enc_valid_out,
  input wire logic enc_ready_in,
  output logic enc_validity_out
);
  import alb_pkg::*;

  // Control register state
  logic loopback_enable;
  logic loopback_order;
  logic [1:0] loopback_mode;
  logic spdif_transmit_enable;
  logic left_subframe_validity;
  logic right_subframe_validity;
  logic gb_clk;
  logic gb_hf;
  logic gb_clr;
  logic gb_sm;

  // Derived and datapath state
  alb_state_t state;
  alb_state_t next_state;
  logic loop_active;
  logic [31:0] next_rdata;
  logic wr_lb;
  logic wr_sp;
  logic wr_gb;
  logic [NSER-1:0] next_rx;

  alb_fifo_if #(.W(DW), .D(DEPTH)) fq ();

  // Write decode, one register per strobe
  assign wr_lb = reg_wr_in && (reg_addr_in == OFS_LB);
  assign wr_sp = reg_wr_in && (reg_addr_in == OFS_SP);
  assign wr_gb = reg_wr_in && (reg_addr_in == OFS_GBL);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      loopback_enable <= RST_BIT;
      loopback_order <= RST_BIT;
      loopback_mode <= RST_MODE;
    end else if (wr_lb) begin
      loopback_enable <= reg_wdata_in[LB_EN_BIT];
      loopback_order <= reg_wdata_in[LB_ORD_BIT];
      loopback_mode <= reg_wdata_in[LB_MODE_HI:LB_MODE_LO];
    end
  end

  // taken whatever the dividers do
  // Writes are not gated by the sequencer; software keeps it held
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      spdif_transmit_enable <= RST_BIT;
      left_subframe_validity <= RST_BIT;
      right_subframe_validity <= RST_BIT;
    end else if (wr_sp) begin
      spdif_transmit_enable <= reg_wdata_in[SP_EN_BIT];
      left_subframe_validity <= reg_wdata_in[SP_VL_BIT];
      right_subframe_validity <= reg_wdata_in[SP_VR_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gb_clk <= RST_BIT;
      gb_hf <= RST_BIT;
      gb_clr <= RST_BIT;
      gb_sm <= RST_BIT;
    end else if (wr_gb) begin
      gb_clk <= reg_wdata_in[GB_CLK_BIT];
      gb_hf <= reg_wdata_in[GB_HF_BIT];
      gb_clr <= reg_wdata_in[GB_CLR_BIT];
      gb_sm <= reg_wdata_in[GB_SM_BIT];
    end
  end

  // Reset controls go out as active-low holds
  assign tx_sm_rst_b_out = gb_sm;
  assign tx_ser_clr_b_out = gb_clr;
  assign tx_clkdiv_rst_b_out = gb_clk;
  assign tx_hfdiv_rst_b_out = gb_hf;

  // Read mux, unmapped offsets answer zero
  always_comb begin
    next_rdata = RD_NONE;
    case (reg_addr_in)
      OFS_LB: begin
        next_rdata[LB_EN_BIT] = loopback_enable;
        next_rdata[LB_ORD_BIT] = loopback_order;
        next_rdata[LB_MODE_HI:LB_MODE_LO] = loopback_mode;
      end
      OFS_SP: begin
        next_rdata[SP_EN_BIT] = spdif_transmit_enable;
        next_rdata[SP_VL_BIT] = left_subframe_validity;
        next_rdata[SP_VR_BIT] = right_subframe_validity;
      end
      OFS_GBL: begin
        next_rdata[GB_CLK_BIT] = gb_clk;
        next_rdata[GB_HF_BIT] = gb_hf;
        next_rdata[GB_CLR_BIT] = gb_clr;
        next_rdata[GB_SM_BIT] = gb_sm;
      end
      OFS_STAT: begin
        next_rdata[ST_LOOP_BIT] = loop_active;
        next_rdata[ST_RUN_BIT] = (state == ALB_ST_RUN);
        next_rdata[ST_LVL_HI:ST_LVL_LO] = LVW'(fq.level);
      end
      default: next_rdata = RD_NONE;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= RD_NONE;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= RD_NONE;
    end
  end

  assign loop_active = loopback_enable && !spdif_transmit_enable;

  // transmit generators shared
  // Reserved codes share nothing, so a bad value cannot clock receive
  assign rx_use_tx_gen_out = loopback_enable &&
                             (loopback_mode == MODE_TX_GEN);

  assign spdif_transmit_mode_out = spdif_transmit_enable;

  // Transmit sequencer follows the two global holds
  always_comb begin
    case (state)
      ALB_ST_HELD: next_state = !gb_sm ? ALB_ST_HELD :
                   (gb_clr ? ALB_ST_RUN : ALB_ST_CLEAR);
      ALB_ST_CLEAR: next_state = !gb_sm ? ALB_ST_HELD :
                    (gb_clr ? ALB_ST_RUN : ALB_ST_CLEAR);
      ALB_ST_RUN: next_state = !gb_sm ? ALB_ST_HELD :
                  (gb_clr ? ALB_ST_RUN : ALB_ST_CLEAR);
      default: next_state = ALB_ST_HELD;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ALB_ST_HELD;
    end else begin
      state <= next_state;
    end
  end

  // Per-serializer loopback routing of the receive bits
  for (genvar n = 0; n < NSER; n++) begin : g_ser
    localparam int P = n ^ 1;
    logic rx_loop;
    assign rx_loop = loop_active &&
                     (loopback_order ? (n % 2 == 1) : (n % 2 == 0));
    assign next_rx[n] = rx_loop ? ser_tx_bit_in[P] : pin_data_in[n];
  end

  // Received bits register; cleared serializers see zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ser_rx_bit_out <= '0;
    end else if (!gb_clr) begin
      ser_rx_bit_out <= '0;
    end else begin
      ser_rx_bit_out <= next_rx;
    end
  end

  // Transmit pins; enable is low while driving
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_data_out <= '0;
      pin_oe_b_out <= '1;
    end else begin
      pin_data_out <= gb_clr ? ser_tx_bit_in : '0;
      pin_oe_b_out <= gb_clr ? ~ser_dir_in : '1;
    end
  end

  // Sample stream; clearing the serializers flushes stale audio
  assign fq.in_data = sample_in;
  assign fq.in_valid = sample_valid_in;
  assign sample_ready_out = fq.in_ready;
  assign fq.flush = !gb_clr;
  assign fq.out_ready = enc_ready_in && (state == ALB_ST_RUN);
  assign enc_sample_out = fq.out_data;
  assign enc_valid_out = fq.out_valid && (state == ALB_ST_RUN);

  alb_fifo #(.W(DW), .D(DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .f(fq.fifo)
  );

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enc_validity_out <= RST_BIT;
    end else if (spdif_transmit_enable) begin
      enc_validity_out <= tx_slot_odd_in ? right_subframe_validity
                                         : left_subframe_validity;
    end else begin
      enc_validity_out <= RST_BIT;
    end
  end

  // Checks on the design's own outputs and internal state
  property p_gen_share;
    @(posedge clock_in) disable iff (!rst_b_in)
    rx_use_tx_gen_out |-> loopback_enable &&
                          loopback_mode == MODE_TX_GEN;
  endproperty
  a_gen_share: assert property (p_gen_share)
    else $error("receive shares transmit generators without cause");

  property p_mode_ignored;
    @(posedge clock_in) disable iff (!rst_b_in)
    !loopback_enable |-> !rx_use_tx_gen_out;
  endproperty
  a_mode_ignored: assert property (p_mode_ignored)
    else $error("generator mode honoured with loopback off");

  property p_odd_to_even;
    @(posedge clock_in) disable iff (!rst_b_in)
    loop_active && !loopback_order && gb_clr
      |=> ser_rx_bit_out[0] == $past(ser_tx_bit_in[1]);
  endproperty
  a_odd_to_even: assert property (p_odd_to_even)
    else $error("serializer 0 did not receive from 1");

  property p_even_to_odd;
    @(posedge clock_in) disable iff (!rst_b_in)
    loop_active && loopback_order && gb_clr
      |=> ser_rx_bit_out[1] == $past(ser_tx_bit_in[0]);
  endproperty
  a_even_to_odd: assert property (p_even_to_odd)
    else $error("serializer 1 did not receive from 0");

  property p_pin_path;
    @(posedge clock_in) disable iff (!rst_b_in)
    !loop_active && gb_clr
      |=> ser_rx_bit_out[0] == $past(pin_data_in[0]);
  endproperty
  a_pin_path: assert property (p_pin_path)
    else $error("receiver off its pin outside loopback");

  property p_tdm_only;
    @(posedge clock_in) disable iff (!rst_b_in)
    spdif_transmit_enable |-> !loop_active;
  endproperty
  a_tdm_only: assert property (p_tdm_only)
    else $error("loopback active in S/PDIF mode");

  property p_right_v;
    @(posedge clock_in) disable iff (!rst_b_in)
    spdif_transmit_enable && tx_slot_odd_in
      |=> enc_validity_out == $past(right_subframe_validity);
  endproperty
  a_right_v: assert property (p_right_v)
    else $error("right subframe validity wrong");

  property p_left_v;
    @(posedge clock_in) disable iff (!rst_b_in)
    spdif_transmit_enable && !tx_slot_odd_in
      |=> enc_validity_out == $past(left_subframe_validity);
  endproperty
  a_left_v: assert property (p_left_v)
    else $error("left subframe validity wrong");

  property p_reserved;
    @(posedge clock_in) disable iff (!rst_b_in)
    reg_rd_in && (reg_addr_in == OFS_LB || reg_addr_in == OFS_SP)
      |=> reg_rdata_out[31:4] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_en_write;
    @(posedge clock_in) disable iff (!rst_b_in)
    wr_sp |=> spdif_transmit_mode_out == $past(reg_wdata_in[SP_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("transmit mode write not taken");

  property p_held;
    @(posedge clock_in) disable iff (!rst_b_in)
    !gb_sm |=> !enc_valid_out;
  endproperty
  a_held: assert property (p_held)
    else $error("samples offered while sequencer held");

  property p_enable;
    @(posedge clock_in) disable iff (!rst_b_in)
    wr_lb && !reg_wdata_in[LB_EN_BIT] |=> !loop_active;
  endproperty
  a_enable: assert property (p_enable)
    else $error("loopback still active after clear");

endmodule // alb_ctrl

// file: hw/alb_pkg.sv
// Shared constants and types for the audio loopback and S/PDIF control block
package alb_pkg;

  // Structure sizes
  localparam int NSER = 4;
  localparam int DW = 32;
  localparam int DEPTH = 8;
  localparam int AW = 8;
  localparam int LVW = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_GBL = 8'h44;
  localparam logic [7:0] OFS_LB = 8'h4C;
  localparam logic [7:0] OFS_SP = 8'h50;
  localparam logic [7:0] OFS_STAT = 8'h58;

  // Loopback control fields
  localparam int LB_EN_BIT = 0;
  localparam int LB_ORD_BIT = 1;
  localparam int LB_MODE_LO = 2;
  localparam int LB_MODE_HI = 3;
  localparam logic [1:0] MODE_DEF = 2'h0;
  localparam logic [1:0] MODE_TX_GEN = 2'h1;

  // S/PDIF transmit control fields
  localparam int SP_EN_BIT = 0;
  localparam int SP_VL_BIT = 2;
  localparam int SP_VR_BIT = 3;

  // Global control fields, zero holds the logic in reset
  localparam int GB_CLK_BIT = 8;
  localparam int GB_HF_BIT = 9;
  localparam int GB_CLR_BIT = 10;
  localparam int GB_SM_BIT = 11;

  // Status fields
  localparam int ST_LOOP_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_LVL_LO = 4;
  localparam int ST_LVL_HI = 7;

  // Reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [31:0] RD_NONE = 32'h0;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    ALB_ST_HELD = 3'h1,
    ALB_ST_CLEAR = 3'h2,
    ALB_ST_RUN = 3'h4
  } alb_state_t;

endpackage

// file: hw/alb_fifo_if.sv
// Stream carrier between the control block and its sample FIFO
`timescale 1ns/100ps
interface alb_fifo_if #(parameter int W = 32, parameter int D = 8);
  logic [W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  logic flush;
  logic [$clog2(D):0] level;
  modport fifo (input in_data, in_valid, out_ready, flush,
                output in_ready, out_data, out_valid, level);
  modport user (output in_data, in_valid, out_ready, flush,
                input in_ready, out_data, out_valid, level);
endinterface

// file: hw/alb_fifo.sv
// Sample FIFO with flush, storage in flip-flops
`timescale 1ns/100ps
module alb_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  alb_fifo_if.fifo f
);
  localparam int PW = $clog2(D);
  localparam logic [PW:0] FULL = (PW+1)'(D);

  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // Handshakes; pointers wrap naturally since depth is a power of two
  assign push = f.in_valid & f.in_ready;
  assign pop = f.out_valid & f.out_ready;
  assign f.in_ready = !f.flush && (count != FULL);
  assign f.out_valid = (count != '0);
  assign f.out_data = mem[rd_ptr];
  assign f.level = count;

  // Storage
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= f.in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (f.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

endmodule // alb_fifo

// file: tb/alb_partner.sv
// Far-side codec model for the serial data pins
`timescale 1ns/100ps
module alb_partner
  import alb_pkg::*;
(
  input wire logic [alb_pkg::NSER-1:0] dev_oe_b_in,
  input wire logic [alb_pkg::NSER-1:0] dev_data_in,
  input wire logic [alb_pkg::NSER-1:0] codec_data_in,
  output logic [alb_pkg::NSER-1:0] pin_out
);
  // Wire level: the device wins where it drives, else the codec talks,
  // so a pin never shows a stale device value once released
  always_comb begin
    for (int i = 0; i < NSER; i++) begin
      pin_out[i] = dev_oe_b_in[i] ? codec_data_in[i] : dev_data_in[i];
    end
  end
endmodule // alb_partner

// file: tb/testbench.sv
// Self-checking bench for the loopback and S/PDIF control block
`timescale 1ns/100ps
module testbench;
  import alb_pkg::*;
  logic clock_in, rst_b, reg_wr, reg_rd, slot_odd, rx_use, sp_mode;
  logic sm_b, clr_b, clk_b, hf_b, validity;
  logic sample_valid, sample_ready, enc_valid, enc_ready;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sample_data, enc_sample;
  logic [3:0] ser_dir, ser_tx, pin_wire, pin_data, pin_oe_b, ser_rx, codec;
  int fails, checks;

  alb_ctrl alb_ctrl_inst (.clock_in(clock_in), .rst_b_in(rst_b),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .ser_dir_in(ser_dir),
    .ser_tx_bit_in(ser_tx), .pin_data_in(pin_wire), .pin_data_out(pin_data),
    .pin_oe_b_out(pin_oe_b), .ser_rx_bit_out(ser_rx),
    .tx_slot_odd_in(slot_odd), .rx_use_tx_gen_out(rx_use),
    .spdif_transmit_mode_out(sp_mode), .tx_sm_rst_b_out(sm_b),
    .tx_ser_clr_b_out(clr_b), .tx_clkdiv_rst_b_out(clk_b),
    .tx_hfdiv_rst_b_out(hf_b), .sample_in(sample_data),
    .sample_valid_in(sample_valid), .sample_ready_out(sample_ready),
    .enc_sample_out(enc_sample), .enc_valid_out(enc_valid),
    .enc_ready_in(enc_ready), .enc_validity_out(validity));

  alb_partner alb_partner_inst (.dev_oe_b_in(pin_oe_b),
    .dev_data_in(pin_data), .codec_data_in(codec), .pin_out(pin_wire));

  // 250 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout;
    fails++;
    $display("Error at %0t: wait limit used up", $time);
    end_of_test;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock_in);
    reg_wr <= 1'b0;
    // Let the register update of this edge settle before callers look
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock_in);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // One cycle of serializer traffic, then the masked receive bits
  task automatic lb_chk(input logic [3:0] tx, cod, mask, exp);
    @(posedge clock_in);
    ser_tx <= tx;
    codec <= cod;
    @(posedge clock_in);
    #1;
    chk({28'h0, ser_rx & mask}, {28'h0, exp});
  endtask

  task automatic push(input logic [31:0] d);
    int n;
    @(posedge clock_in);
    sample_data <= d;
    sample_valid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      #1;
      if (sample_ready === 1'b1) break;
      @(posedge clock_in);
    end
    if (n == 20) timeout;
    @(posedge clock_in);
    sample_valid <= 1'b0;
  endtask

  task automatic pop(input logic [31:0] exp);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clock_in);
      #1;
      if (enc_valid === 1'b1) break;
    end
    if (n == 20) timeout;
    chk(enc_sample, exp);
    @(posedge clock_in);
    enc_ready <= 1'b1;
    @(posedge clock_in);
    enc_ready <= 1'b0;
  endtask

  initial begin
    fails = 0;
    checks = 0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, slot_odd, sample_valid, enc_ready} = 5'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    sample_data = 32'h0;
    {ser_dir, ser_tx, codec} = 12'h0;
    repeat (8) @(posedge clock_in);
    rst_b <= 1'b1;
    // Reset values and reserved bits
    rd(OFS_LB, 32'h0);
    rd(OFS_SP, 32'h0);
    rd(OFS_GBL, 32'h0);
    wr(OFS_LB, 32'hFFFFFFF5);
    rd(OFS_LB, 32'h00000005);
    chk({31'h0, rx_use}, 32'h1);
    wr(OFS_SP, 32'hFFFFFFFF);
    rd(OFS_SP, 32'h0000000D);
    chk({31'h0, sp_mode}, 32'h1);
    wr(OFS_SP, 32'h0);
    #1;
    chk({31'h0, sp_mode}, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0);
    $display("registers test done, mismatches %0d", fails);
    // Global control: each bit releases its own logic
    wr(OFS_GBL, 32'h00000F00);
    rd(OFS_GBL, 32'h00000F00);
    chk({28'h0, sm_b, clr_b, hf_b, clk_b}, 32'hF);
    // directions match order 0: odd serializers transmit
    @(posedge clock_in);
    ser_dir <= 4'b1010;
    lb_chk(4'b0010, 4'b0000, 4'b0101, 4'b0001);
    lb_chk(4'b1000, 4'b0000, 4'b0101, 4'b0100);
    rd(OFS_STAT, 32'h00000003);
    chk({28'h0, pin_oe_b}, 32'h5);
    chk({28'h0, pin_data}, 32'h8);
    // directions match order 1: even serializers transmit
    @(posedge clock_in);
    ser_dir <= 4'b0101;
    wr(OFS_LB, 32'h7);
    lb_chk(4'b0001, 4'b1111, 4'b1010, 4'b0010);
    lb_chk(4'b0100, 4'b1111, 4'b1010, 4'b1000);
    // mode back to 00 with loopback off
    @(posedge clock_in);
    ser_dir <= 4'b1010;
    wr(OFS_LB, 32'h0);
    chk({31'h0, rx_use}, 32'h0);
    lb_chk(4'b1010, 4'b0100, 4'b0101, 4'b0100);
    // sequencer held in reset while the enable changes
    wr(OFS_LB, 32'h5);
    wr(OFS_GBL, 32'h00000700);
    wr(OFS_SP, 32'h1);
    wr(OFS_GBL, 32'h00000F00);
    lb_chk(4'b1010, 4'b0100, 4'b0101, 4'b0100);
    wr(OFS_GBL, 32'h00000700);
    $display("loopback test done, mismatches %0d", fails);
    // Validity bits per subframe, dividers left running
    for (int v = 0; v < 4; v++) begin
      wr(OFS_SP, {28'h0, v[1:0], 2'b01});
      chk({31'h0, sp_mode}, 32'h1);
      for (int s = 0; s < 2; s++) begin
        @(posedge clock_in);
        slot_odd <= s[0];
        @(posedge clock_in);
        #1;
        chk({31'h0, validity}, {31'h0, s[0] ? v[1] : v[0]});
      end
    end
    wr(OFS_SP, 32'h0);
    wr(OFS_LB, 32'h0);
    $display("validity test done, mismatches %0d", fails);
    // Sample FIFO filled to refusal, then drained in order
    wr(OFS_GBL, 32'h00000F00);
    for (int i = 0; i < DEPTH; i++) begin
      push(32'hA5000000 + i);
    end
    @(posedge clock_in);
    #1;
    chk({31'h0, sample_ready}, 32'h0);
    rd(OFS_STAT, 32'h00000082);
    for (int i = 0; i < DEPTH; i++) begin
      pop(32'hA5000000 + i);
    end
    rd(OFS_STAT, 32'h00000002);
    // Serializer clear flushes what is held
    push(32'h0000005A);
    wr(OFS_GBL, 32'h00000B00);
    chk({31'h0, sample_ready}, 32'h0);
    // Flush and sequencer step take effect one edge after the write
    @(posedge clock_in);
    #1;
    chk({30'h0, sample_ready, enc_valid}, 32'h0);
    $display("fifo test done, mismatches %0d", fails);
    end_of_test;
  end
endmodule // testbench
